// ==== led_link_pkg.sv ====
// Constants and types shared by both ends of the two-wire LED control link.
package led_link_pkg;

	// Bus address that the target answers to.
	localparam logic [6:0] DEV_ADDR        = 7'h40;
	// General-call address with the write direction bit.
	localparam logic [7:0] GCALL_WR        = 8'h00;
	// Only data byte that arms the bus reset call.
	localparam logic [7:0] RESET_CALL_BYTE = 8'h06;
	// Register offsets reached through the pointer byte.
	localparam logic [7:0] FIRST_MODE_REGISTER_OFS       = 8'h00;
	localparam logic [7:0] MODE2_OFS       = 8'h01;
	// Sleep control inside the first mode register.
	localparam int         SLEEP_BIT       = 4;
	// Push-pull select inside the output mode register.
	localparam int         DRIVE_BIT       = 2;
	// Power-up values: asleep, and outputs in push-pull mode.
	localparam logic [7:0] FIRST_MODE_REGISTER_RST       = 8'h10;
	localparam logic [7:0] MODE2_RST       = 8'h04;
	// Bit counter values: last data bit and acknowledge slot.
	localparam logic [3:0] LAST_BIT        = 4'h7;
	localparam logic [3:0] ACK_SLOT        = 4'h8;
	// Controller clock period and serial clock period.
	localparam int         CLK_PERIOD_NS   = 10;
	localparam int         SCL_PERIOD_NS   = 1000;
	// Controller cycles in one quarter of a serial clock period.
	localparam int         QTR_CYC         = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [7:0] QTR_LAST        = 8'(QTR_CYC - 1);

	// Target byte-level states.
	typedef enum logic [2:0] {
		T_IDLE  = 3'h0,
		T_ADDR  = 3'h1,
		T_PTR   = 3'h2,
		T_WDATA = 3'h3,
		T_READ  = 3'h4,
		T_GCALL = 3'h5,
		T_DONE  = 3'h6
	} tgt_state_e;

	// Controller commands.
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_STOP  = 2'h1,
		OP_WRITE = 2'h2,
		OP_READ  = 2'h3
	} host_op_e;

	// Controller sequencer states.
	typedef enum logic [1:0] {
		H_IDLE  = 2'h0,
		H_START = 2'h1,
		H_STOP  = 2'h2,
		H_BYTE  = 2'h3
	} host_state_e;

endpackage

// ==== led_link_if.sv ====
// Two-wire link between the controller and the LED controller target.
interface led_link_if;
	logic scl;         // Serial clock, driven by the controller.
	logic host_sda_o;  // Controller data output value.
	logic host_sda_oe; // Controller pulls the data line.
	logic dev_sda_o;   // Target data output value.
	logic dev_sda_oe;  // Target pulls the data line.
	logic sda;         // Resolved open-drain data line level.

	// Open-drain data line with a pull-up: low when any end pulls low.
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	// Controller end.
	modport host (
		output scl,
		output host_sda_o,
		output host_sda_oe,
		input  sda
	);

	// Target end.
	modport device (
		input  scl,
		output dev_sda_o,
		output dev_sda_oe,
		input  sda
	);
endinterface

// ==== led_target.sv ====
// Two-wire target end of the LED controller with mode register handling.
// Behaviour
// R1 - Byte count per transfer is unlimited.
// R2 - Each byte is followed by one acknowledge slot.
// R3 - Addressed receiving target acknowledges every byte.
// R4 - Controller acknowledges every read byte but last.
// R5 - Acknowledger holds data low through clock high.
// R6 - Controller ends a read by not acknowledging.
// R7 - Target releases data after a missing acknowledge.
// R8 - Sleep set stops both PWM clock sources.
// R9 - Outputs selectable, push-pull after reset.
// R10 - Data edges during clock high are start/stop.
// R11 - Acknowledged reset call restores defaults at stop.
// R12 - Target releases data after its acknowledge slot.
module led_target
	import led_link_pkg::*;
(
	input  wire logic clock,      // System clock for the PWM side.
	input  wire logic rst_n,      // Asynchronous reset, active low.
	led_link_if.device link,      // Two-wire link, clocked by its own clock.
	output logic      osc_run,    // Internal oscillator may run.
	output logic      ext_run,    // External clock input is passed on.
	output logic      push_pull,  // Output drivers in push-pull mode.
	output logic      soft_reset, // One-cycle pulse after a reset call.
	output logic [7:0] first_mode_register,     // Current first mode register.
	output logic [7:0] mode2      // Current output mode register.
);

	// ---- Link clock domain ----
	tgt_state_e st_r;        // Byte-level state.
	logic [3:0] bit_cnt_r;   // Bit position inside the current byte.
	logic [7:0] shift_r;     // Received bits, sampled on rising clock.
	logic [7:0] tx_r;        // Byte being shifted out on a read.
	logic [7:0] ptr_r;       // Register pointer.
	logic       sda_oe_r;    // Target pulls the data line.
	logic       host_ack_r;  // Controller acknowledged the last read byte.
	logic       arm_r;       // Reset call accepted, waiting for stop.
	logic       wr_tog_r;    // Toggles once per written register byte.
	logic [7:0] wr_addr_r;   // Offset of the written byte.
	logic [7:0] wr_data_r;   // Value of the written byte.
	logic       start_tog_r; // Toggled by each start condition.
	logic       start_seen_r;// Last start toggle handled.
	logic [7:0] m1_s1_r;     // Mode register copies for reads.
	logic [7:0] m1_s2_r;
	logic [7:0] m2_s1_r;
	logic [7:0] m2_s2_r;

	// Decoding of the received byte and of the read value.
	wire        start_hit  = start_tog_r ^ start_seen_r;
	wire        addr_match = shift_r[7:1] == DEV_ADDR;
	wire        gcall_hit  = shift_r == GCALL_WR;
	wire        reset_byte = shift_r == RESET_CALL_BYTE;
	wire        rd_is_m2   = ptr_r == MODE2_OFS;
	wire [7:0]  rd_byte    = rd_is_m2 ? m2_s2_r : m1_s2_r;
	wire        in_ack     = bit_cnt_r == ACK_SLOT;

	// A falling data line while the clock is high marks a start; the
	// toggle settles a full hold time before the clock falls, so the
	// falling-edge logic can compare it safely. [R10]
	always_ff @(negedge link.sda or negedge rst_n) begin
		if (!rst_n) begin
			start_tog_r <= 1'b0;
		end else if (link.scl) begin
			start_tog_r <= ~start_tog_r; // [R10]
		end
	end

	// Rising clock: sample data bits and the controller's answer.
	always_ff @(posedge link.scl or negedge rst_n) begin
		if (!rst_n) begin
			shift_r    <= 8'h00;
			host_ack_r <= 1'b0;
		end else begin
			if (in_ack) begin
				// Low data in the slot means acknowledge. [R2] [R5]
				host_ack_r <= ~link.sda;
			end else begin
				shift_r <= {shift_r[6:0], link.sda};
			end
		end
	end

	// Mode values cross into the link domain through two flip-flops.
	always_ff @(negedge link.scl or negedge rst_n) begin
		if (!rst_n) begin
			m1_s1_r <= FIRST_MODE_REGISTER_RST;
			m1_s2_r <= FIRST_MODE_REGISTER_RST;
			m2_s1_r <= MODE2_RST;
			m2_s2_r <= MODE2_RST;
		end else begin
			m1_s1_r <= first_mode_register;
			m1_s2_r <= m1_s1_r;
			m2_s1_r <= mode2;
			m2_s2_r <= m2_s1_r;
		end
	end

	// Falling clock: byte framing, acknowledge drive and data out.
	always_ff @(negedge link.scl or negedge rst_n) begin
		if (!rst_n) begin
			st_r         <= T_IDLE;
			bit_cnt_r    <= 4'h0;
			tx_r         <= 8'h00;
			ptr_r        <= 8'h00;
			sda_oe_r     <= 1'b0;
			arm_r        <= 1'b0;
			wr_tog_r     <= 1'b0;
			wr_addr_r    <= 8'h00;
			wr_data_r    <= 8'h00;
			start_seen_r <= 1'b0;
		end else begin
			start_seen_r <= start_tog_r;
			if (start_hit) begin
				// A start, repeated or not, opens a new address byte.
				st_r      <= T_ADDR; // [R10]
				bit_cnt_r <= 4'h0;
				sda_oe_r  <= 1'b0;
				arm_r     <= 1'b0;
			end else if (bit_cnt_r == LAST_BIT) begin
				// Eighth bit is in: decide the acknowledge slot. [R2]
				bit_cnt_r <= ACK_SLOT;
				sda_oe_r  <= 1'b0;
				case (st_r)
					T_ADDR: begin
						if (addr_match) begin
							sda_oe_r <= 1'b1; // [R3]
							st_r     <= shift_r[0] ? T_READ : T_PTR;
						end else if (gcall_hit) begin
							sda_oe_r <= 1'b1; // [R11]
							st_r     <= T_GCALL;
						end else begin
							st_r <= T_IDLE;
						end
					end
					T_PTR: begin
						sda_oe_r <= 1'b1; // [R3]
						ptr_r    <= shift_r;
						st_r     <= T_WDATA;
					end
					T_WDATA: begin
						// Any number of data bytes, each acknowledged. [R1]
						sda_oe_r  <= 1'b1; // [R3]
						wr_addr_r <= ptr_r;
						wr_data_r <= shift_r;
						wr_tog_r  <= ~wr_tog_r;
						ptr_r     <= ptr_r + 8'h01;
					end
					T_GCALL: begin
						// Only the reset byte is acknowledged. [R11]
						sda_oe_r <= reset_byte;
						arm_r    <= reset_byte;
						st_r     <= T_DONE;
					end
					T_DONE: begin
						// Extra bytes break the call format. [R11]
						arm_r <= 1'b0;
					end
					default: begin
						// Idle or reading: the slot belongs to others.
						sda_oe_r <= 1'b0;
					end
				endcase
			end else if (in_ack) begin
				// Slot over: let go of the line first. [R12]
				bit_cnt_r <= 4'h0;
				sda_oe_r  <= 1'b0; // [R12]
				if (st_r == T_READ) begin
					if (host_ack_r) begin
						// Acknowledged: drive the next byte's first bit.
						tx_r     <= {rd_byte[6:0], 1'b0};
						sda_oe_r <= ~rd_byte[7];
						ptr_r    <= ptr_r + 8'h01;
					end else begin
						// No acknowledge: keep the line high. [R7]
						st_r <= T_IDLE;
					end
				end
			end else begin
				// Data bits; a read shifts out the next bit.
				bit_cnt_r <= bit_cnt_r + 4'h1;
				if (st_r == T_READ && bit_cnt_r != 4'h6) begin
					sda_oe_r <= ~tx_r[7];
					tx_r     <= {tx_r[6:0], 1'b0};
				end else if (st_r == T_READ) begin
					sda_oe_r <= ~tx_r[7];
				end
			end
		end
	end

	// The target only ever pulls low.
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = sda_oe_r;

	// ---- System clock domain ----
	logic       scl_s1_r;   // Serial clock synchroniser.
	logic       scl_s2_r;
	logic       sda_s1_r;   // Data line synchroniser.
	logic       sda_s2_r;
	logic       sda_d_r;    // Previous synchronised data level.
	logic       wt_s1_r;    // Write toggle synchroniser.
	logic       wt_s2_r;
	logic       wt_d_r;     // Previous synchronised write toggle.
	logic       arm_s1_r;   // Reset-call arm synchroniser.
	logic       arm_s2_r;
	logic [7:0] first_mode_register_r;    // First mode register.
	logic [7:0] mode2_r;    // Output mode register.
	logic       osc_run_r;  // Oscillator run enable.
	logic       ext_run_r;  // External clock run enable.
	logic       pp_r;       // Push-pull select.
	logic       srst_r;     // Reset-call pulse.

	// Stop is a rising data line while the clock is high. [R10]
	wire stop_hit = scl_s2_r & sda_s2_r & ~sda_d_r;
	wire wr_hit   = wt_s2_r ^ wt_d_r;
	wire call_hit = stop_hit & arm_s2_r;

	// Synchronisers for the serial clock, data line, write toggle and reset-call arm from the link.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
			wt_s1_r  <= 1'b0;
			wt_s2_r  <= 1'b0;
			wt_d_r   <= 1'b0;
			arm_s1_r <= 1'b0;
			arm_s2_r <= 1'b0;
		end else begin
			scl_s1_r <= link.scl;
			scl_s2_r <= scl_s1_r;
			sda_s1_r <= link.sda;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
			wt_s1_r  <= wr_tog_r;
			wt_s2_r  <= wt_s1_r;
			wt_d_r   <= wt_s2_r;
			arm_s1_r <= arm_r;
			arm_s2_r <= arm_s1_r;
		end
	end

	// Mode registers: written bytes land here; a reset call restores
	// power-up values on its stop. Address and data are held stable
	// for a whole byte after each toggle, so they are read directly.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			first_mode_register_r <= FIRST_MODE_REGISTER_RST;
			mode2_r <= MODE2_RST; // [R9]
			srst_r  <= 1'b0;
		end else begin
			srst_r <= call_hit;
			if (call_hit) begin
				first_mode_register_r <= FIRST_MODE_REGISTER_RST; // [R11]
				mode2_r <= MODE2_RST; // [R11]
			end else if (wr_hit && wr_addr_r == FIRST_MODE_REGISTER_OFS) begin
				first_mode_register_r <= wr_data_r;
			end else if (wr_hit && wr_addr_r == MODE2_OFS) begin
				mode2_r <= wr_data_r;
			end
		end
	end

	// Clock source gating and driver mode, each from a flip-flop.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			osc_run_r <= ~FIRST_MODE_REGISTER_RST[SLEEP_BIT];
			ext_run_r <= ~FIRST_MODE_REGISTER_RST[SLEEP_BIT];
			pp_r      <= MODE2_RST[DRIVE_BIT];
		end else begin
			osc_run_r <= ~first_mode_register_r[SLEEP_BIT]; // [R8]
			ext_run_r <= ~first_mode_register_r[SLEEP_BIT]; // [R8]
			pp_r      <= mode2_r[DRIVE_BIT];  // [R9]
		end
	end

	assign osc_run    = osc_run_r;
	assign ext_run    = ext_run_r;
	assign push_pull  = pp_r;
	assign soft_reset = srst_r;
	assign first_mode_register      = first_mode_register_r;
	assign mode2      = mode2_r;

endmodule

// ==== led_host.sv ====
// Two-wire bus controller end: byte commands in, serial clock and data out.
module led_host
	import led_link_pkg::*;
(
	input  wire logic       clock,     // Controller clock.
	input  wire logic       rst_n,     // Asynchronous reset, active low.
	led_link_if.host        link,      // Two-wire link.
	input  wire logic       cmd_valid, // Command request, one cycle.
	input  wire logic [1:0] cmd_op,    // Command code, see host_op_e.
	input  wire logic [7:0] cmd_data,  // Byte to send for a write.
	input  wire logic       cmd_last,  // Read: last byte, no acknowledge.
	output logic            busy,      // Command in progress.
	output logic            done,      // Command finished, one cycle.
	output logic [7:0]      rd_data,   // Byte received by a read.
	output logic            ack_seen   // Write byte was acknowledged.
);

	host_state_e st_r;       // Sequencer state.
	logic [7:0]  qcnt_r;     // Cycles inside the current quarter.
	logic [1:0]  phase_r;    // Quarter of the serial bit.
	logic [3:0]  bit_r;      // Bit of the byte, 8 is the acknowledge.
	logic        rd_r;       // Current byte is a read.
	logic        last_r;     // Current read is the last one.
	logic [7:0]  sh_r;       // Shift register for both directions.
	logic        scl_r;      // Serial clock output.
	logic        oe_r;       // Data line pulled low.
	logic        busy_r;     // Busy flag.
	logic        done_r;     // Done pulse.
	logic [7:0]  rd_r8;      // Last read byte.
	logic        ack_r;      // Acknowledge result.
	logic        sda_s1_r;   // Data line synchroniser.
	logic        sda_s2_r;

	// Quarter timing and bit position decoding.
	wire q_end    = qcnt_r == QTR_LAST;
	wire ph_end   = q_end && phase_r == 2'h3;
	wire ack_bit  = bit_r == ACK_SLOT;
	wire accept   = cmd_valid && st_r == H_IDLE;
	// Value to pull for this bit: data bits of a write, or the answer
	// slot of a read, which acknowledges all but the last. [R4] [R6]
	wire pull_bit = rd_r ? (ack_bit && !last_r) : (!ack_bit && !sh_r[7]);

	// Data line synchroniser.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
		end else begin
			sda_s1_r <= link.sda;
			sda_s2_r <= sda_s1_r;
		end
	end

	// Quarter-period divider that paces the serial clock.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			qcnt_r  <= 8'h00;
			phase_r <= 2'h0;
		end else if (st_r == H_IDLE || q_end) begin
			qcnt_r  <= 8'h00;
			phase_r <= (st_r == H_IDLE) ? 2'h0 : phase_r + 2'h1;
		end else begin
			qcnt_r <= qcnt_r + 8'h01;
		end
	end

	// Command sequencer: builds start, stop and byte waveforms.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r   <= H_IDLE;
			bit_r  <= 4'h0;
			rd_r   <= 1'b0;
			last_r <= 1'b0;
			sh_r   <= 8'h00;
			scl_r  <= 1'b1;
			oe_r   <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			rd_r8  <= 8'h00;
			ack_r  <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (st_r)
				H_IDLE: begin
					if (accept) begin
						busy_r <= 1'b1;
						bit_r  <= 4'h0;
						rd_r   <= cmd_op == OP_READ;
						last_r <= cmd_last;
						sh_r   <= cmd_data;
						case (cmd_op)
							OP_START: st_r <= H_START;
							OP_STOP:  st_r <= H_STOP;
							default:  st_r <= H_BYTE;
						endcase
					end
				end
				H_START: begin
					// Release, clock high, pull data low, clock low. [R10]
					if (q_end) begin
						case (phase_r)
							2'h0:    oe_r  <= 1'b0;
							2'h1:    scl_r <= 1'b1;
							2'h2:    oe_r  <= 1'b1; // [R10]
							default: scl_r <= 1'b0;
						endcase
					end
					if (ph_end) begin
						st_r   <= H_IDLE;
						busy_r <= 1'b0;
						done_r <= 1'b1;
					end
				end
				H_STOP: begin
					// Data low, clock high, then release data. [R10]
					if (q_end) begin
						case (phase_r)
							2'h0:    oe_r  <= 1'b1;
							2'h1:    scl_r <= 1'b1;
							2'h2:    oe_r  <= 1'b0; // [R10]
							default: scl_r <= 1'b1;
						endcase
					end
					if (ph_end) begin
						st_r   <= H_IDLE;
						busy_r <= 1'b0;
						done_r <= 1'b1;
					end
				end
				H_BYTE: begin
					// Eight data bits and one answer slot. [R2] [R1]
					if (q_end) begin
						case (phase_r)
							2'h0:    oe_r  <= pull_bit;
							2'h1:    scl_r <= 1'b1;
							2'h2: begin
								// Sample in the middle of clock high. [R5]
								if (ack_bit) begin
									ack_r <= ~sda_s2_r;
								end else begin
									sh_r <= {sh_r[6:0], sda_s2_r};
								end
							end
							default: scl_r <= 1'b0;
						endcase
					end
					if (ph_end) begin
						bit_r <= bit_r + 4'h1;
						if (ack_bit) begin
							// Let go of the line after the slot. [R5]
							oe_r   <= 1'b0;
							rd_r8  <= rd_r ? sh_r : rd_r8;
							st_r   <= H_IDLE;
							busy_r <= 1'b0;
							done_r <= 1'b1;
						end
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	assign link.scl         = scl_r;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = oe_r;
	assign busy             = busy_r;
	assign done             = done_r;
	assign rd_data          = rd_r8;
	assign ack_seen         = ack_r;

endmodule

// ==== led_link_chk.sv ====
// Concurrent checks on the two-wire link between controller and target.
module led_link_chk
	import led_link_pkg::*;
(
	input wire logic clock,       // Controller clock used for sampling.
	input wire logic rst_n,       // Asynchronous reset, active low.
	input wire logic scl,         // Serial clock.
	input wire logic host_sda_o,  // Controller data value.
	input wire logic host_sda_oe, // Controller pulls data low.
	input wire logic dev_sda_o,   // Target data value.
	input wire logic dev_sda_oe,  // Target pulls data low.
	input wire logic sda          // Resolved data line.
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       scl_q;   // Serial clock one sample ago.
	logic       sda_q;   // Data line one sample ago.
	logic [3:0] bitc_r;  // Clock pulses since start or the last slot.
	logic [1:0] byte_r;  // Bytes finished in this transfer, saturating.
	logic [7:0] shift_r; // Last eight bits seen on the line.
	logic       gc_r;    // Transfer opened with the general-call write.
	logic       nack_r;  // Some slot of this transfer went unanswered.
	wire        rise  = scl & ~scl_q;                // Clock rising.
	wire        start = scl & scl_q & sda_q & ~sda;  // Start seen.
	wire        ack   = rise & (bitc_r == ACK_SLOT); // Slot sampled.

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Follow bit and byte position; sampling is safe as the link is slow.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			bitc_r  <= 4'h0;
			byte_r  <= 2'h0;
			shift_r <= 8'h00;
			gc_r    <= 1'b0;
			nack_r  <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start) begin
				bitc_r <= 4'h0;
				byte_r <= 2'h0;
				nack_r <= 1'b0;
			end else if (ack) begin
				bitc_r <= 4'h0;
				byte_r <= byte_r + {1'b0, byte_r != 2'h3};
				nack_r <= nack_r | sda;
				if (byte_r == 2'h0)
					gc_r <= (shift_r == GCALL_WR);
			end else if (rise) begin
				bitc_r  <= bitc_r + 4'h1;
				shift_r <= {shift_r[6:0], sda};
			end
		end
	end

	a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("target drive changed while clock high");
	a_ack_held: assert property (
		rise && dev_sda_oe |=> dev_sda_oe [*8])
		else $error("target pull dropped in clock high phase");
	a_addr_answer: assert property (ack && byte_r == 2'h0 |->
		dev_sda_oe == (shift_r[7:1] == DEV_ADDR || shift_r == GCALL_WR))
		else $error("wrong answer to an address byte");
	a_reset_byte: assert property (ack && gc_r && byte_r == 2'h1 |->
		dev_sda_oe == (shift_r == RESET_CALL_BYTE))
		else $error("wrong answer to the reset call byte");
	a_extra_nack: assert property (ack && gc_r && byte_r[1] |-> !dev_sda_oe)
		else $error("byte after the reset call was answered");
	a_nack_release: assert property (nack_r && scl |-> !dev_sda_oe)
		else $error("target pulls data after a missing answer");
	a_start_host: assert property (start |-> host_sda_oe && !dev_sda_oe)
		else $error("start not made by the controller");
	a_addr_listen: assert property (
		scl && !ack && byte_r == 2'h0 && bitc_r != 4'h0 |-> !dev_sda_oe)
		else $error("target pulls data during an address bit");

	c_addr_acked: cover property (ack && byte_r == 2'h0 && dev_sda_oe);
	c_reset_acked: cover property (ack && gc_r && byte_r == 2'h1 && sda == 1'b0);
	c_read_nacked: cover property (ack && sda && byte_r != 2'h0);
endmodule

// ==== tb_i2c_target_acknowledge_logic.sv ====
// Self-checking bench driving both ends of the two-wire LED link.
`define CHECK(nm, ex, got) \
	begin \
		total_checks++; \
		if ((got) !== (ex)) begin \
			n_errors++; \
			$display("BAD %s expected %h seen %h", nm, ex, got); \
		end \
	end

module tb_i2c_target_acknowledge_logic
	import led_link_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clock, rst_n;          // Shared clock and reset.
	logic       cmd_valid, cmd_last;   // Command strobe and last read.
	logic [1:0] cmd_op;                // Command code.
	logic [7:0] cmd_data, rd_data;     // Byte sent and byte read.
	logic       busy, done, ack_seen;  // Controller status.
	logic       osc_run, ext_run;      // Clock source enables.
	logic       push_pull, soft_reset; // Drive mode and reset pulse.
	logic [7:0] first_mode_register, mode2;          // Target registers.
	logic [7:0] m1_x, m2_x;            // Expected register contents.
	int         n_errors = 0;          // Mismatches seen.
	int         total_checks = 0;      // Comparisons made.
	int         n_soft = 0;            // Reset pulses counted.

	// Free-running system clock.
	initial clock = 1'b0;
	always #5 clock = ~clock;

	led_link_if i_led_link_if ();
	led_target i_led_target (.clock(clock), .rst_n(rst_n),
		.link(i_led_link_if.device), .osc_run(osc_run), .ext_run(ext_run),
		.push_pull(push_pull), .soft_reset(soft_reset), .first_mode_register(first_mode_register),
		.mode2(mode2));
	led_host i_led_host (.clock(clock), .rst_n(rst_n),
		.link(i_led_link_if.host), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_data(cmd_data), .cmd_last(cmd_last), .busy(busy), .done(done),
		.rd_data(rd_data), .ack_seen(ack_seen));
	led_link_chk i_led_link_chk (.clock(clock), .rst_n(rst_n),
		.scl(i_led_link_if.scl), .host_sda_o(i_led_link_if.host_sda_o),
		.host_sda_oe(i_led_link_if.host_sda_oe),
		.dev_sda_o(i_led_link_if.dev_sda_o),
		.dev_sda_oe(i_led_link_if.dev_sda_oe), .sda(i_led_link_if.sda));

	// Count one-cycle reset pulses, sampled where they have settled.
	always @(negedge clock) begin
		if (soft_reset === 1'b1)
			n_soft++;
	end

	// Print the counts and the verdict, then stop.
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Issue one controller command and wait a bounded time for done.
	task automatic cmd(input logic [1:0] op, input logic [7:0] d,
		input logic last);
		int n;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		cmd_last = last;
		@(negedge clock);
		cmd_valid = 1'b0;
		`CHECK("busy taken", 1'b1, busy)
		n = 0;
		while (done !== 1'b1 && n < 1200) begin
			@(negedge clock);
			n++;
		end
		if (n >= 1200) begin
			n_errors++;
			$display("BAD done expected 1 seen timeout");
			summarize();
		end
		`CHECK("busy done", 1'b0, busy)
	endtask

	// Send one byte and compare the answer in its slot.
	task automatic wr(input logic [7:0] b, input logic ak, input string nm);
		cmd(OP_WRITE, b, 1'b0);
		`CHECK(nm, ak, ack_seen)
	endtask

	// Answer expected for the first byte of a transfer.
	function automatic logic addr_ack(input logic [7:0] b);
		return (b[7:1] == DEV_ADDR) || (b == GCALL_WR);
	endfunction

	// Byte expected from a read at the given pointer.
	function automatic logic [7:0] rd_exp(input logic [7:0] p);
		return (p == MODE2_OFS) ? m2_x : m1_x;
	endfunction

	// Compare registers and the outputs decoded from them.
	task automatic chk_regs();
		repeat (2) @(negedge clock);
		`CHECK("first_mode_register", m1_x, first_mode_register)
		`CHECK("mode2", m2_x, mode2)
		`CHECK("osc_run", ~m1_x[SLEEP_BIT], osc_run)
		`CHECK("ext_run", ~m1_x[SLEEP_BIT], ext_run)
		`CHECK("push_pull", m2_x[DRIVE_BIT], push_pull)
	endtask

	// Main sequence: reset, writes, read back, foreign and reset calls.
	initial begin
		logic [7:0] a;
		int         k;
		int         s;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_data = 8'h00;
		cmd_last = 1'b0;
		void'($urandom(27));
		repeat (6) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		m1_x = FIRST_MODE_REGISTER_RST;
		m2_x = MODE2_RST;
		chk_regs();
		$display("Test reset values done");
		// Corner values first, then random ones, with extra bytes.
		for (k = 0; k < 4; k++) begin
			m1_x = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			m2_x = (k == 0) ? 8'hfb : (k == 1) ? 8'h04 : 8'($urandom);
			cmd(OP_START, 8'h00, 1'b0);
			wr({DEV_ADDR, 1'b0}, 1'b1, "addr ack");
			wr(FIRST_MODE_REGISTER_OFS, 1'b1, "pointer ack");
			wr(m1_x, 1'b1, "first_mode_register ack");
			wr(m2_x, 1'b1, "mode2 ack");
			repeat (k) wr(8'($urandom), 1'b1, "extra ack");
			cmd(OP_STOP, 8'h00, 1'b0);
			chk_regs();
		end
		$display("Test register writes done");
		// Pointer write, repeated start, two reads, the last unanswered.
		cmd(OP_START, 8'h00, 1'b0);
		wr({DEV_ADDR, 1'b0}, 1'b1, "addr ack");
		wr(MODE2_OFS, 1'b1, "pointer ack");
		cmd(OP_START, 8'h00, 1'b0);
		wr({DEV_ADDR, 1'b1}, 1'b1, "read addr ack");
		cmd(OP_READ, 8'h00, 1'b0);
		`CHECK("read mode2", rd_exp(MODE2_OFS), rd_data)
		cmd(OP_READ, 8'h00, 1'b1);
		`CHECK("read next", rd_exp(8'h02), rd_data)
		cmd(OP_STOP, 8'h00, 1'b0);
		$display("Test read back done");
		// Foreign addresses and the general-call read go unanswered.
		for (k = 0; k < 3; k++) begin
			a = (k == 0) ? 8'h01 : 8'($urandom);
			if (addr_ack(a))
				a = {DEV_ADDR ^ 7'h01, 1'b0};
			cmd(OP_START, 8'h00, 1'b0);
			wr(a, addr_ack(a), "foreign addr");
			wr(8'($urandom), 1'b0, "ignored byte");
			cmd(OP_STOP, 8'h00, 1'b0);
			chk_regs();
		end
		$display("Test foreign addresses done");
		// Wrong data byte, trailing byte, then a clean reset call.
		for (k = 0; k < 3; k++) begin
			a = (k == 0) ? (8'($urandom) | 8'h80) : RESET_CALL_BYTE;
			s = n_soft;
			cmd(OP_START, 8'h00, 1'b0);
			wr(GCALL_WR, 1'b1, "gcall ack");
			wr(a, k != 0, "reset byte");
			if (k == 1)
				wr(8'($urandom), 1'b0, "trailing byte");
			cmd(OP_STOP, 8'h00, 1'b0);
			if (k == 2) begin
				m1_x = FIRST_MODE_REGISTER_RST;
				m2_x = MODE2_RST;
			end
			chk_regs();
			`CHECK("soft reset", (k == 2) ? 1 : 0, n_soft - s)
		end
		$display("Test reset calls done");
		summarize();
	end
endmodule
